// [inc/fi_pkg.sv]
// Purpose: constants, register map and carriers of the fault indicator aggregator
// Assumes: one 40 MHz clock, synchronous active-high reset, AHB-Lite register access
// Notes: event inputs are one-cycle pulses; switch and card inputs are levels
package fi_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_MASK = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_INFO = 8'h0c;

  // status and mask bit positions
  localparam int ST_W = 10;
  localparam int ST_ACCESS = 0;
  localparam int ST_CYCLE = 1;
  localparam int ST_TASK = 2;
  localparam int ST_SUPPLY = 3;
  localparam int ST_DIAG = 4;
  localparam int ST_SWAP = 5;
  localparam int ST_REDUND = 6;
  localparam int ST_MEMCOR = 7;
  localparam int ST_PROG = 8;
  localparam int ST_CARD = 9;

  // control register fields
  localparam int CTRL_W = 8;
  localparam int CT_MEDIA_LO = 0;
  localparam int CT_PORT_LO = 2;
  localparam int CT_PROG_INT = 6;
  localparam int CT_PROG_EXT = 7;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'hc0;

  // info register fields
  localparam int IN_LAMP_LO = 0;
  localparam int IN_RACK = 3;
  localparam int IN_CARD = 4;
  localparam int IN_STOP = 5;
  localparam int IN_CAUSE_LO = 8;
  localparam int IN_DIAG_LO = 16;

  localparam int DIAG_W = 8;
  localparam int PORTS = 4;
  localparam logic [3:0] CAUSE_NONE = 4'h0;
  localparam logic [3:0] CAUSE_MEM_MGMT = 4'h1;

  // one-cycle event pulses from the operating system and i/o subsystem
  typedef struct packed {
    logic module_no_response;
    logic cycle_overrun;
    logic task_request_err;
    logic start_info_overflow;
    logic tod_interrupt_err;
    logic battery_empty;
    logic battery_missing;
    logic supply_input_fail;
    logic io_diag_incoming;
    logic sync_diag_incoming;
    logic diag_outgoing;
    logic module_swapped;
    logic wrong_module_type;
    logic sync_module_removed;
    logic cpu_redundancy_loss;
    logic station_loss;
    logic bus_master_fail;
    logic mem_err_corrected;
    logic task_block_absent;
    logic instance_block_bad;
    logic image_update_fail;
  } fi_events_t;

  typedef struct packed {
    logic internal_fault_lamp;
    logic external_fault_lamp;
    logic redundancy_fault_lamp;
  } fi_lamps_t;

  typedef struct packed {
    logic stop_req;
    logic memreset_req;
    logic [3:0] stop_cause;
  } fi_stop_t;

endpackage

// [rtl/fi_aggregator.sv]
// Purpose: gathers fault events into sticky status and drives the three fault lamps
// Assumes: event inputs are one-cycle pulses synchronous to clk
// Notes: ahb-lite slave with zero wait states, always okay
`timescale 1ns/10ps

module fi_aggregator (
  input wire logic clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // fault sources
  input wire fi_pkg::fi_events_t events,
  input wire logic rack_switch_up,
  input wire logic capacity_card_present,
  // operator side and controller side
  output fi_pkg::fi_lamps_t lamps,
  output logic rack_number,
  output fi_pkg::fi_stop_t stop,
  output logic [fi_pkg::PORTS-1:0] ring_port,
  output logic irq
);
  import fi_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [CTRL_W-1:0] ctrl;
    logic [DIAG_W-1:0] diag_cnt;
    fi_lamps_t lamps;
    logic rack;
    fi_stop_t stop;
    logic [PORTS-1:0] ring;
    logic irq;
    logic [31:0] rdata;
    logic wr_pend;
    logic [7:0] wr_addr;
  } fi_state_t;

  fi_state_t s_q;
  fi_state_t s_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // saturating counter step; both incoming sources may fire together
  function automatic logic [DIAG_W-1:0] diag_step(
    input logic [DIAG_W-1:0] cnt,
    input logic [1:0] inc,
    input logic dec
  );
    logic [DIAG_W+1:0] t;
    t = {2'b00, cnt} + {{DIAG_W{1'b0}}, inc};
    if (dec && t != '0) begin
      t = t - {{(DIAG_W+1){1'b0}}, 1'b1};
    end
    if (t > {2'b00, {DIAG_W{1'b1}}}) begin
      t = {2'b00, {DIAG_W{1'b1}}};
    end
    diag_step = t[DIAG_W-1:0];
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [31:0] read_word(input fi_state_t s, input logic [7:0] a);
    logic [31:0] w;
    w = '0;
    if (hit(a, OFF_STATUS)) begin
      w[ST_W-1:0] = s.status;
    end else if (hit(a, OFF_MASK)) begin
      w[ST_W-1:0] = s.mask;
    end else if (hit(a, OFF_CTRL)) begin
      w[CTRL_W-1:0] = s.ctrl;
    end else if (hit(a, OFF_INFO)) begin
      w[IN_LAMP_LO +: 3] = s.lamps;
      w[IN_RACK] = s.rack;
      w[IN_CARD] = ~s.status[ST_CARD] | ~s.stop.stop_req;
      w[IN_STOP] = s.stop.stop_req;
      w[IN_CAUSE_LO +: 4] = s.stop.stop_cause;
      w[IN_DIAG_LO +: DIAG_W] = s.diag_cnt;
    end
    read_word = w;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [ST_W-1:0] ev_set;
  logic [ST_W-1:0] w1c;
  logic [1:0] diag_inc;
  logic [ST_W-1:0] st_new;
  logic [1:0] media_en;
  logic prog_int;
  logic prog_ext;
  logic addr_ok;

  always_comb begin
    s_d = s_q;
    ev_set = '0;
    w1c = '0;

    ev_set[ST_ACCESS] = events.module_no_response;
    ev_set[ST_CYCLE] = events.cycle_overrun;
    ev_set[ST_TASK] = events.task_request_err | events.start_info_overflow
      | events.tod_interrupt_err;
    ev_set[ST_SUPPLY] = events.battery_empty | events.battery_missing
      | events.supply_input_fail;
    ev_set[ST_DIAG] = events.io_diag_incoming | events.sync_diag_incoming;
    ev_set[ST_SWAP] = events.module_swapped | events.wrong_module_type
      | events.sync_module_removed;
    ev_set[ST_REDUND] = events.cpu_redundancy_loss | events.station_loss
      | events.bus_master_fail;
    ev_set[ST_MEMCOR] = events.mem_err_corrected;
    ev_set[ST_PROG] = events.task_block_absent | events.instance_block_bad
      | events.image_update_fail;
    // the card is a level: the flag is re-set every cycle it stays absent
    ev_set[ST_CARD] = ~capacity_card_present;

    // data phase of a write lands here
    if (s_q.wr_pend) begin
      if (hit(s_q.wr_addr, OFF_STATUS)) begin
        w1c = hwdata[ST_W-1:0];
      end
      if (hit(s_q.wr_addr, OFF_MASK)) begin
        s_d.mask = hwdata[ST_W-1:0];
      end
      if (hit(s_q.wr_addr, OFF_CTRL)) begin
        s_d.ctrl = hwdata[CTRL_W-1:0];
      end
    end

    // a new event beats a clear in the same cycle
    st_new = (s_q.status & ~w1c) | ev_set;
    s_d.status = st_new;

    // pending diagnostic interrupts: incoming counts up, outgoing down
    diag_inc = {1'b0, events.io_diag_incoming} + {1'b0, events.sync_diag_incoming};
    s_d.diag_cnt = diag_step(s_q.diag_cnt, diag_inc, events.diag_outgoing);

    prog_int = s_q.ctrl[CT_PROG_INT];
    prog_ext = s_q.ctrl[CT_PROG_EXT];

    // lamps follow pending status, not the mask, so software masking
    // the interrupt never hides a fault from the operator
    s_d.lamps.internal_fault_lamp = st_new[ST_CYCLE] | st_new[ST_TASK]
      | st_new[ST_MEMCOR] | (prog_int & st_new[ST_PROG]);
    s_d.lamps.external_fault_lamp = st_new[ST_ACCESS] | st_new[ST_SUPPLY]
      | st_new[ST_SWAP] | (prog_ext & st_new[ST_PROG])
      | (s_d.diag_cnt != '0);
    s_d.lamps.redundancy_fault_lamp = st_new[ST_REDUND];

    s_d.rack = rack_switch_up;

    // stop and memory reset held for as long as no card is seen
    if (!capacity_card_present) begin
      s_d.stop.stop_req = 1'b1;
      s_d.stop.memreset_req = 1'b1;
      s_d.stop.stop_cause = CAUSE_MEM_MGMT;
    end else begin
      s_d.stop.stop_req = 1'b0;
      s_d.stop.memreset_req = 1'b0;
    end

    // a port is a ring port only while its interface runs media redundancy
    media_en = s_q.ctrl[CT_MEDIA_LO +: 2];
    for (int i = 0; i < PORTS; i++) begin
      s_d.ring[i] = s_q.ctrl[CT_PORT_LO + i] & media_en[i / 2];
    end

    s_d.irq = |(st_new & s_q.mask);

    // address phase; reads are sampled here so data stands in the data phase
    addr_ok = hsel & htrans[1] & hready;
    s_d.wr_pend = addr_ok & hwrite;
    s_d.wr_addr = haddr[7:0];
    if (addr_ok && !hwrite) begin
      s_d.rdata = read_word(s_q, haddr[7:0]);
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q.status <= '0;
      s_q.mask <= '0;
      s_q.ctrl <= CTRL_RESET;
      s_q.diag_cnt <= '0;
      s_q.lamps <= '0;
      s_q.rack <= 1'b0;
      s_q.stop.stop_req <= 1'b0;
      s_q.stop.memreset_req <= 1'b0;
      s_q.stop.stop_cause <= CAUSE_NONE;
      s_q.ring <= '0;
      s_q.irq <= 1'b0;
      s_q.rdata <= '0;
      s_q.wr_pend <= 1'b0;
      s_q.wr_addr <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hrdata = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign lamps = s_q.lamps;
  assign rack_number = s_q.rack;
  assign stop = s_q.stop;
  assign ring_port = s_q.ring;
  assign irq = s_q.irq;

endmodule

// [verification/fi_asserts.sv]
// Purpose: port checks of the fault aggregator
// Assumes: events are one-cycle pulses
// Notes: register effects are left to the bench
`timescale 1ns/10ps
module fi_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire fi_pkg::fi_events_t events,
  input wire logic rack_switch_up,
  input wire logic capacity_card_present,
  input wire fi_pkg::fi_lamps_t lamps,
  input wire logic rack_number,
  input wire fi_pkg::fi_stop_t stop
);
  import fi_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire ext_ev = events.module_no_response | events.battery_empty | events.battery_missing
    | events.supply_input_fail | events.module_swapped | events.wrong_module_type
    | events.sync_module_removed;
  wire time_ev = events.cycle_overrun | events.task_request_err
    | events.start_info_overflow | events.tod_interrupt_err;
  wire red_ev = events.cpu_redundancy_loss | events.station_loss | events.bus_master_fail;
  // --
  // lamps
  // --
  a_ext_sources: assert property (ext_ev |=> lamps.external_fault_lamp)
    else $error("external lamp missed a fault");
  // an outgoing pulse in the same cycle can net the count to zero
  a_diag_ext: assert property (
    (events.io_diag_incoming | events.sync_diag_incoming) && !events.diag_outgoing
    |=> lamps.external_fault_lamp) else $error("external lamp missed a diagnostic");
  a_time_int: assert property (time_ev |=> lamps.internal_fault_lamp)
    else $error("internal lamp missed a time error");
  a_memfix_int: assert property (
    events.mem_err_corrected |=> lamps.internal_fault_lamp) else $error("memory fix unseen");
  a_red_lamp: assert property (red_ev |=> lamps.redundancy_fault_lamp)
    else $error("redundancy lamp missed a fault");
  a_lamps_reset: assert property ($fell(rst) |-> lamps == 3'h0)
    else $error("lamp lit after reset");
  // --
  // card and rack
  // --
  a_card_stop: assert property (
    !capacity_card_present |=> stop.stop_req && stop.memreset_req
    && stop.stop_cause == CAUSE_MEM_MGMT) else $error("no stop without card");
  a_card_release: assert property (capacity_card_present |=> !stop.stop_req)
    else $error("stop held with card present");
  a_rack_follow: assert property (1'b1 |=> rack_number == $past(rack_switch_up))
    else $error("rack number off the switch");
  c_diag: cover property (events.io_diag_incoming);
  c_card: cover property (!capacity_card_present);
  c_rack: cover property (rack_number);
endmodule
bind fi_aggregator fi_asserts u_chk (
  .clk(clk), .rst(rst), .events(events), .rack_switch_up(rack_switch_up),
  .capacity_card_present(capacity_card_present), .lamps(lamps),
  .rack_number(rack_number), .stop(stop)
);

// [verification/fi_partner.sv]
// Purpose: operating system, i/o and panel side of the aggregator
// Assumes: bench calls the tasks from one process
// Notes: pulses last one cycle, levels change after an edge
`timescale 1ns/10ps
module fi_partner (
  input wire logic clk,
  output fi_pkg::fi_events_t events,
  output logic rack_switch_up,
  output logic capacity_card_present
);
  import fi_pkg::*;
  initial begin
    events = '0;
    rack_switch_up = 1'b0;
    capacity_card_present = 1'b1;
  end
  task automatic fire(input fi_events_t ev);
    @(posedge clk);
    events <= ev;
    @(posedge clk);
    events <= '0;
  endtask
  task automatic levels(input logic sw, input logic card);
    @(posedge clk);
    rack_switch_up <= sw;
    capacity_card_present <= card;
  endtask
endmodule

// [verification/fi_aggregator_tb.sv]
// Purpose: self-checking bench of the fault aggregator
// Assumes: zero-wait ahb-lite slave
// Notes: control and mask drawn at random
`timescale 1ns/10ps
module fi_aggregator_tb;
  import fi_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, rack_number, irq, rack_switch_up, capacity_card_present;
  fi_events_t events;
  fi_lamps_t lamps;
  fi_stop_t stop;
  logic [PORTS-1:0] ring_port;
  logic [7:0] ct, dg;
  logic [9:0] mk;
  int mismatches = 0;
  int samples_checked = 0;
  int st_of[21] = '{8, 8, 8, 7, 6, 6, 6, 5, 5, 5, -1, 4, 4, 3, 3, 3, 2, 2, 2, 1, 0};
  always #12.5 clk = ~clk;
  fi_aggregator u_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .events(events), .rack_switch_up(rack_switch_up),
    .capacity_card_present(capacity_card_present), .lamps(lamps), .rack_number(rack_number),
    .stop(stop), .ring_port(ring_port), .irq(irq));
  fi_partner u_part (.clk(clk), .events(events), .rack_switch_up(rack_switch_up),
    .capacity_card_present(capacity_card_present));
  // --
  // helpers
  // --
  task automatic end_sim;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  function automatic logic [2:0] lamp_of(input logic [9:0] s, input logic [7:0] c,
    input logic [7:0] d);
    lamp_of[2] = s[1] | s[2] | s[7] | (s[8] & c[6]);
    lamp_of[1] = s[0] | s[3] | s[5] | (d != 8'h0) | (s[8] & c[7]);
    lamp_of[0] = s[6];
  endfunction
  function automatic logic [3:0] ring_of(input logic [7:0] c);
    for (int i = 0; i < 4; i++) begin
      ring_of[i] = c[2+i] & c[i/2];
    end
  endfunction
  // mid holds info bits 15:3 (rack, card ok, stop, cause)
  task automatic check_all(input logic [9:0] s, input logic [12:0] mid = 13'h2);
    repeat (2) @(posedge clk);
    rd_chk(OFF_STATUS, {22'h0, s}, "status");
    rd_chk(OFF_INFO, {8'h0, dg, mid, lamp_of(s, ct, dg)}, "info");
    chk("lamps", {29'h0, lamp_of(s, ct, dg)}, lamps);
    chk("irq", {31'h0, |(s & mk)}, irq);
    chk("ring", {28'h0, ring_of(ct)}, ring_port);
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
  endtask
  // --
  // tests
  // --
  initial begin
    rd = $urandom(32'h5bb68431);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_chk(OFF_CTRL, 32'hc0, "ctrl");
    rd_chk(OFF_MASK, 32'h0, "mask");
    for (int e = 0; e < 21; e++) begin
      if (e == 10) continue;
      ct = $urandom;
      mk = $urandom;
      bus(1'b1, OFF_CTRL, {24'h0, ct});
      bus(1'b1, OFF_MASK, {22'h0, mk});
      dg = (e == 11 || e == 12) ? 8'h1 : 8'h0;
      u_part.fire(fi_events_t'(21'h1 << e));
      check_all(10'h1 << st_of[e]);
      bus(1'b1, OFF_STATUS, 32'h3ff);
      if (dg != 8'h0) u_part.fire(fi_events_t'(21'h400));
      dg = 8'h0;
      check_all(10'h0);
    end
    u_part.fire(fi_events_t'(21'h1800));
    u_part.fire(fi_events_t'(21'h400));
    dg = 8'h1;
    check_all(10'h10);
    u_part.fire(fi_events_t'(21'h400));
    dg = 8'h0;
    check_all(10'h10);
    bus(1'b1, OFF_STATUS, 32'h10);
    bus(1'b1, OFF_INFO, 32'hffffffff);
    rd_chk(8'h10, 32'h0, "unmapped");
    u_part.levels(1'b1, 1'b0);
    check_all(10'h200, 13'h25);
    chk("stop", 32'h31, stop);
    chk("rack", 32'h1, rack_number);
    u_part.levels(1'b1, 1'b1);
    bus(1'b1, OFF_STATUS, 32'h200);
    check_all(10'h0, 13'h23);
    chk("stop", 32'h1, stop);
    end_sim;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim;
  end
endmodule
